// ===== design/tsrb_pkg.sv
// package of register map, field layout and reset values for the bank
package tsrb_pkg;
  // ******************************************************************
  // register offsets
  // ******************************************************************
  localparam logic [7:0] OFS_HYST_CFG = 8'h25; // hysteresis setting
  localparam logic [7:0] OFS_DEV_STATUS = 8'h30; // device status byte
  localparam logic [7:0] OFS_TEMP_LOW = 8'h31; // sensed temp low byte
  localparam logic [7:0] OFS_TEMP_HIGH = 8'h32; // sensed temp high byte
  // ******************************************************************
  // reset values
  // ******************************************************************
  localparam logic [2:0] RST_HYST_CODE = 3'h1; // 1.0 degree default
  localparam logic [7:0] RST_DEV_STATUS = 8'h00; // status default
  localparam logic [10:0] RST_TEMP = 11'h000; // sensed temp default
  // ******************************************************************
  // field positions
  // ******************************************************************
  localparam int HYST_MSB = 2; // hysteresis code top bit
  localparam int STAT_IRQ_BIT = 7; // pending interrupt
  localparam int STAT_NVM_BIT = 3; // nvm write in progress
  localparam int STAT_WPO_BIT = 2; // override permit
  localparam int LOW_TEMP_LSB = 2; // temp bits sit at [7:2] of low byte
  localparam int HIGH_TEMP_MSB = 4; // sign sits at bit 4 of high byte
  // ******************************************************************
  // hysteresis codes and widths in quarter degrees
  // ******************************************************************
  localparam logic [2:0] HYS_CODE_1P0 = 3'h1; // 1.0 C
  localparam logic [2:0] HYS_CODE_1P5 = 3'h2; // 1.5 C
  localparam logic [2:0] HYS_CODE_3P0 = 3'h3; // 3.0 C
  localparam logic [2:0] HYS_CODE_6P0 = 3'h4; // 6.0 C
  localparam logic [4:0] HYS_Q_NONE = 5'h00; // no hysteresis
  localparam logic [4:0] HYS_Q_1P0 = 5'h04; // 4 quarters
  localparam logic [4:0] HYS_Q_1P5 = 5'h06; // 6 quarters
  localparam logic [4:0] HYS_Q_3P0 = 5'h0C; // 12 quarters
  localparam logic [4:0] HYS_Q_6P0 = 5'h18; // 24 quarters
endpackage : tsrb_pkg

// ===== design/tsrb_limit_cmp.sv
// one limit comparator with hysteresis for the temperature bank
`timescale 1ns/10ps
module tsrb_limit_cmp (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic signed [10:0] temp_in, // quarter degrees
  input wire logic signed [10:0] limit_in, // quarter degrees
  input wire logic [4:0] hyst_in, // hysteresis in quarter degrees
  input wire logic above_mode_in, // 1: trip when above, 0: when below
  output logic trip_out // registered trip flag
);
  // ******************************************************************
  // threshold selection
  // ******************************************************************
  logic signed [12:0] temp_x; // widened to avoid overflow at range ends
  logic signed [12:0] limit_x; // widened limit
  logic signed [12:0] release_x; // level at which a trip releases
  assign temp_x = 13'(temp_in);
  assign limit_x = 13'(limit_in);
  // release point moved away from the limit by the hysteresis
  assign release_x = above_mode_in ? (limit_x - 13'(hyst_in))
                                   : (limit_x + 13'(hyst_in));
  // trip sets once past the limit, clears at or beyond the release point
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      trip_out <= 1'b0;
    end else if (above_mode_in) begin
      if (temp_x > limit_x) begin
        trip_out <= 1'b1;
      end else if (temp_x <= release_x) begin
        trip_out <= 1'b0;
      end
    end else begin
      if (temp_x < limit_x) begin
        trip_out <= 1'b1;
      end else if (temp_x >= release_x) begin
        trip_out <= 1'b0;
      end
    end
  end
endmodule // tsrb_limit_cmp

// ===== design/tsrb_bank.sv
// thermal hysteresis, device status and sensed temperature registers
//
// Operation
// (R1) decode hysteresis code to width, others none
// (R2) same width for normal and critical limits
// (R3) status bit 7 shows pending interrupt
// (R4) status bit 3 shows nvm write busy
// (R5) host writes ignored while write busy
// (R6) busy flag clears itself when write ends
// (R7) status bit 2 shows override permit
// (R8) permit from strap at power-on, direct ground
// (R9) sensed temp readable at 0x31 and 0x32
// (R10) eleven-bit quarter-degree value, unused bits zero
// (R11) read-only registers and reserved bits unchanged
`timescale 1ns/10ps
module tsrb_bank
  import tsrb_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] reg_addr_in, // register offset from bus engine
  input wire logic reg_wr_in, // one-cycle write strobe
  input wire logic [7:0] reg_wdata_in, // write data
  input wire logic reg_rd_in, // one-cycle read strobe
  input wire logic irq_pending_in, // interrupt engine has event pending
  input wire logic nvm_wr_start_in, // nvm write begins, pulse
  input wire logic nvm_wr_done_in, // nvm write completes, pulse
  input wire logic address_strap_pin_in, // 1: tied directly to ground
  input wire logic strap_sample_in, // power-on sense strobe
  input wire logic conv_valid_in, // new conversion result, pulse
  input wire logic signed [10:0] conv_temp_in, // quarter degrees
  input wire logic signed [10:0] high_limit_in, // normal high limit
  input wire logic signed [10:0] low_limit_in, // normal low limit
  input wire logic signed [10:0] crit_high_limit_in, // critical high
  input wire logic signed [10:0] crit_low_limit_in, // critical low
  output logic [7:0] reg_rdata_out, // read data, held after read
  output logic [3:0] limit_trip_out, // crit low,crit high,low,high
  output logic [4:0] thermal_hysteresis_width_out // quarter degrees
);
  import tsrb_pkg::*;

  // ******************************************************************
  // decode functions
  // ******************************************************************
  // width of the hysteresis band for a code
  function automatic logic [4:0] hyst_decode(input logic [2:0] code);
    logic [4:0] w;
    w = HYS_Q_NONE;
    // (R1) hysteresis code decode
    unique case (code)
      HYS_CODE_1P0: w = HYS_Q_1P0;
      HYS_CODE_1P5: w = HYS_Q_1P5;
      HYS_CODE_3P0: w = HYS_Q_3P0;
      HYS_CODE_6P0: w = HYS_Q_6P0;
      default: w = HYS_Q_NONE;
    endcase
    return w;
  endfunction

  // address match shared by read and write paths
  function automatic logic addr_hit(input logic [7:0] a,
                                    input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // ******************************************************************
  // state
  // ******************************************************************
  logic [2:0] hyst_code; // host-writable hysteresis code
  logic nvm_write_in_progress; // busy flag
  logic wp_override_permit; // strapped override permit
  logic pending_interrupt_flag; // mirrored interrupt status
  logic [10:0] sensed_temp; // latest conversion result
  logic [7:0] current_temp_low; // low byte image
  logic [7:0] current_temp_high; // high byte image
  logic [7:0] dev_status; // status byte image
  logic [3:0] trips; // comparator results
  logic [4:0] hyst_w; // decoded width
  logic host_wr_ok; // write accepted

  // (R5) drop host writes while busy
  assign host_wr_ok = reg_wr_in && !nvm_write_in_progress;
  assign hyst_w = hyst_decode(hyst_code);

  // ******************************************************************
  // hysteresis register
  // ******************************************************************
  // only bits 2:0 stored; reserved bits read as zero
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      hyst_code <= RST_HYST_CODE;
    end else if (host_wr_ok && addr_hit(reg_addr_in, OFS_HYST_CFG)) begin
      // (R11) reserved bits dropped
      hyst_code <= reg_wdata_in[HYST_MSB:0];
    end
  end

  // ******************************************************************
  // status flags
  // ******************************************************************
  // busy flag: start wins over done in the same cycle
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      nvm_write_in_progress <= 1'b0;
    end else if (nvm_wr_start_in) begin
      nvm_write_in_progress <= 1'b1;
    end else if (nvm_wr_done_in) begin
      // (R6) self clear on completion
      nvm_write_in_progress <= 1'b0;
    end
  end

  // strap is caught by a clocked sample, never by the reset itself
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wp_override_permit <= 1'b0;
    end else if (strap_sample_in) begin
      // (R8) strap sense at power-on
      wp_override_permit <= address_strap_pin_in;
    end
  end

  // interrupt status mirrors the interrupt engine's level
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pending_interrupt_flag <= 1'b0;
    end else begin
      pending_interrupt_flag <= irq_pending_in;
    end
  end

  // ******************************************************************
  // sensed temperature
  // ******************************************************************
  // (R11) no host write path reaches this register
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sensed_temp <= RST_TEMP;
    end else if (conv_valid_in) begin
      sensed_temp <= conv_temp_in;
    end
  end

  // (R10) pack eleven bits, unused bits zero
  always_comb begin
    current_temp_low = {sensed_temp[5:0], 2'b00};
    current_temp_high = {3'b000, sensed_temp[10:6]};
  end

  // (R3) (R4) (R7) status byte assembly
  always_comb begin
    dev_status = RST_DEV_STATUS;
    dev_status[STAT_IRQ_BIT] = pending_interrupt_flag;
    dev_status[STAT_NVM_BIT] = nvm_write_in_progress;
    dev_status[STAT_WPO_BIT] = wp_override_permit;
  end

  // ******************************************************************
  // read path
  // ******************************************************************
  // registered read data; unmapped offsets read zero
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      if (addr_hit(reg_addr_in, OFS_HYST_CFG)) begin
        reg_rdata_out <= {5'h00, hyst_code};
      end else if (addr_hit(reg_addr_in, OFS_DEV_STATUS)) begin
        reg_rdata_out <= dev_status;
      end else if (addr_hit(reg_addr_in, OFS_TEMP_LOW)) begin
        // (R9) low byte offset
        reg_rdata_out <= current_temp_low;
      end else if (addr_hit(reg_addr_in, OFS_TEMP_HIGH)) begin
        // (R9) high byte offset
        reg_rdata_out <= current_temp_high;
      end else begin
        reg_rdata_out <= 8'h00;
      end
    end
  end

  // ******************************************************************
  // limit comparators
  // ******************************************************************
  logic signed [10:0] lim_arr [4]; // limits by index
  assign lim_arr[0] = high_limit_in;
  assign lim_arr[1] = low_limit_in;
  assign lim_arr[2] = crit_high_limit_in;
  assign lim_arr[3] = crit_low_limit_in;

  // (R2) one width for every comparator
  for (genvar i = 0; i < 4; i++) begin : g_cmp
    tsrb_limit_cmp u_cmp (
      .core_clk_in(core_clk_in),
      .sys_rst_in(sys_rst_in),
      .temp_in(sensed_temp),
      .limit_in(lim_arr[i]),
      .hyst_in(hyst_w),
      .above_mode_in(i[0] == 1'b0),
      .trip_out(trips[i])
    );
  end

  // registered outputs
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      limit_trip_out <= 4'h0;
      thermal_hysteresis_width_out <= HYS_Q_1P0;
    end else begin
      limit_trip_out <= trips;
      thermal_hysteresis_width_out <= hyst_w;
    end
  end

  // ******************************************************************
  // checks
  // ******************************************************************
  a_busy_blocks_write: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in) // (R5)
    nvm_write_in_progress && reg_wr_in |=> $stable(hyst_code))
    else $error("write taken while busy");
  a_busy_self_clear: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in) // (R6)
    nvm_wr_done_in && !nvm_wr_start_in |=> !nvm_write_in_progress)
    else $error("busy flag not cleared");
  a_status_read_bits: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in) // (R4)
    reg_rd_in && reg_addr_in == OFS_DEV_STATUS |=>
    reg_rdata_out[3] == $past(nvm_write_in_progress) &&
    reg_rdata_out[7] == $past(pending_interrupt_flag))
    else $error("status byte wrong");
  a_permit_strap: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in) // (R8)
    strap_sample_in |=> wp_override_permit == $past(address_strap_pin_in))
    else $error("permit not from strap");
  a_hyst_decode: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in) // (R1)
    hyst_code > 3'h4 || hyst_code == 3'h0 |=>
    thermal_hysteresis_width_out == HYS_Q_NONE)
    else $error("bad hysteresis width");
  a_temp_high_zero: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in) // (R10)
    reg_rd_in && reg_addr_in == OFS_TEMP_HIGH |=> reg_rdata_out[7:5] == 3'h0)
    else $error("unused temp bits set");
  a_temp_low_read: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in) // (R9)
    reg_rd_in && reg_addr_in == OFS_TEMP_LOW |=>
    reg_rdata_out == {$past(sensed_temp[5:0]), 2'b00})
    else $error("low byte wrong");
  a_ro_unchanged: assert property (@(posedge core_clk_in)
    disable iff (sys_rst_in) // (R11)
    reg_wr_in && !conv_valid_in |=> $stable(sensed_temp))
    else $error("read-only temp changed");
  c_hyst_write: cover property (@(posedge core_clk_in) host_wr_ok &&
    reg_addr_in == OFS_HYST_CFG);
  c_busy_write: cover property (@(posedge core_clk_in)
    nvm_write_in_progress && reg_wr_in);
  c_crit_trip: cover property (@(posedge core_clk_in) trips[2]);
endmodule // tsrb_bank

// ===== tb/tsrb_host_model.sv
// host side model issuing register strobes toward the bank
`timescale 1ns/10ps
module tsrb_host_model (
  input wire logic core_clk_in,
  input wire logic [7:0] reg_rdata_in,
  output logic [7:0] reg_addr_out,
  output logic reg_wr_out,
  output logic [7:0] reg_wdata_out,
  output logic reg_rd_out
);
  // ******************************************************************
  // idle levels: strobes low, data shows no stale value
  // ******************************************************************
  initial begin
    reg_addr_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_wdata_out = 8'h00;
    reg_rd_out = 1'b0;
  end
  // one-cycle write strobe, launched on the falling edge
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_in);
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_wr_out = 1'b1;
    @(negedge core_clk_in);
    reg_wr_out = 1'b0;
    reg_wdata_out = ~d; // inverted so a late sample cannot pass
  endtask
  // one-cycle read strobe; data taken one and a half cycles after the taking edge
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk_in);
    reg_addr_out = a;
    reg_rd_out = 1'b1;
    @(negedge core_clk_in);
    reg_rd_out = 1'b0;
    @(negedge core_clk_in);
    d = reg_rdata_in;
  endtask
endmodule // tsrb_host_model

// ===== tb/tsrb_bank_tb.sv
// self-checking bench for the thermal status register bank
`timescale 1ns/10ps
module tsrb_bank_tb;
  import tsrb_pkg::*;
  // ******************************************************************
  // stimulus and observed signals
  // ******************************************************************
  logic core_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [7:0] addr, wdata, rdata;
  logic wr, rd;
  logic irq = 1'b0, nvm_s = 1'b0, nvm_d = 1'b0;
  logic strap = 1'b0, strap_s = 1'b0, conv_v = 1'b0;
  logic signed [10:0] conv_t = 11'sh000;
  logic signed [10:0] hi_lim = 11'sd100; // normal and critical share it
  logic signed [10:0] lo_lim = -11'sd500; // normal and critical share it; the low side test crosses it
  logic [3:0] trip;
  logic [4:0] width;
  int err_total = 0;
  int compares = 0;
  // 5 ns period clock
  always #2.5 core_clk_in = ~core_clk_in;
  tsrb_host_model host (.core_clk_in(core_clk_in), .reg_rdata_in(rdata),
    .reg_addr_out(addr), .reg_wr_out(wr), .reg_wdata_out(wdata),
    .reg_rd_out(rd));
  tsrb_bank dut (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wdata),
    .reg_rd_in(rd), .irq_pending_in(irq), .nvm_wr_start_in(nvm_s),
    .nvm_wr_done_in(nvm_d), .address_strap_pin_in(strap),
    .strap_sample_in(strap_s), .conv_valid_in(conv_v),
    .conv_temp_in(conv_t), .high_limit_in(hi_lim), .low_limit_in(lo_lim),
    .crit_high_limit_in(hi_lim), .crit_low_limit_in(lo_lim),
    .reg_rdata_out(rdata), .limit_trip_out(trip),
    .thermal_hysteresis_width_out(width));
  // ******************************************************************
  // helpers
  // ******************************************************************
  task automatic check(input logic [10:0] got, input logic [10:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.read_reg(a, d);
    check({3'h0, d}, {3'h0, exp});
  endtask
  // new conversion, then time for the trip pipeline to settle
  task automatic conv(input logic signed [10:0] t);
    @(negedge core_clk_in);
    conv_t = t;
    conv_v = 1'b1;
    @(negedge core_clk_in);
    conv_v = 1'b0;
    repeat (4) @(negedge core_clk_in);
  endtask
  task automatic wrap_up;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ******************************************************************
  // scenarios
  // ******************************************************************
  task automatic t_reset;
    rd_chk(8'h25, 8'h01);
    rd_chk(8'h30, 8'h00);
    rd_chk(8'h31, 8'h00);
    rd_chk(8'h32, 8'h00);
    rd_chk(8'h26, 8'h00);
    check({6'h00, width}, 11'h004);
  endtask
  // every code decoded, reserved bits stay zero
  task automatic t_hyst;
    logic [4:0] ew;
    for (int c = 0; c < 8; c++) begin
      case (c)
        1: ew = 5'h04;
        2: ew = 5'h06;
        3: ew = 5'h0C;
        4: ew = 5'h18;
        default: ew = 5'h00;
      endcase
      host.write_reg(8'h25, {5'h1F, c[2:0]});
      rd_chk(8'h25, {5'h00, c[2:0]});
      check({6'h00, width}, {6'h00, ew});
    end
    host.write_reg(8'h25, 8'h01);
  endtask
  // busy flag blocks writes and clears itself
  task automatic t_status;
    irq = 1'b1;
    strap = 1'b1;
    @(negedge core_clk_in);
    strap_s = 1'b1;
    @(negedge core_clk_in);
    strap_s = 1'b0;
    rd_chk(8'h30, 8'h84);
    nvm_s = 1'b1;
    @(negedge core_clk_in);
    nvm_s = 1'b0;
    rd_chk(8'h30, 8'h8C);
    host.write_reg(8'h25, 8'h04);
    rd_chk(8'h25, 8'h01);
    host.write_reg(8'h30, 8'hFF);
    rd_chk(8'h30, 8'h8C);
    nvm_d = 1'b1;
    @(negedge core_clk_in);
    nvm_d = 1'b0;
    rd_chk(8'h30, 8'h84);
    host.write_reg(8'h25, 8'h04);
    rd_chk(8'h25, 8'h04);
    irq = 1'b0;
    strap = 1'b0;
    @(negedge core_clk_in);
    strap_s = 1'b1;
    @(negedge core_clk_in);
    strap_s = 1'b0;
    rd_chk(8'h30, 8'h00);
    host.write_reg(8'h25, 8'h01);
  endtask
  // byte split of negative and positive results
  task automatic t_temp;
    conv(-11'sd160);
    host.write_reg(8'h31, 8'h00);
    rd_chk(8'h31, 8'h80);
    rd_chk(8'h32, 8'h1D);
    conv(11'sd380);
    host.write_reg(8'h32, 8'h00);
    rd_chk(8'h31, 8'hF0);
    rd_chk(8'h32, 8'h05);
  endtask
  // one width for normal and critical limits
  task automatic t_trips;
    check({7'h00, trip}, 11'h005);
    conv(11'sd97);
    check({7'h00, trip}, 11'h005);
    conv(11'sd96);
    check({7'h00, trip}, 11'h000);
    conv(11'sd101);
    check({7'h00, trip}, 11'h005);
    // low side with a 1.5 C band: release only at limit plus 6 quarters
    host.write_reg(8'h25, 8'h02);
    conv(-11'sd501);
    check({7'h00, trip}, 11'h00A);
    conv(-11'sd495);
    check({7'h00, trip}, 11'h00A);
    conv(-11'sd494);
    check({7'h00, trip}, 11'h000);
  endtask
  // ******************************************************************
  // main sequence and hang guard
  // ******************************************************************
  initial begin
    repeat (6) @(posedge core_clk_in);
    @(negedge core_clk_in);
    sys_rst_in = 1'b0;
    t_reset();
    t_hyst();
    t_status();
    t_temp();
    t_trips();
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge core_clk_in);
    err_total++;
    wrap_up();
  end
endmodule // tsrb_bank_tb
